// ### hdl/eprom_ctl_pkg.sv
// package: pin carriers, modes, timing constants for the eprom programmer/reader
package eprom_ctl_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // ----------------------------------------------------------------
  // timing, figures in their own units
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int T_SETUP_US = 2;
  localparam int T_HOLD_US = 2;
  localparam int T_PW_MS = 50;
  localparam int T_PW_MAX_MS = 55;
  localparam int T_ACC_NS = 550;
  localparam int T_DF_NS = 130;
  localparam int T_VPP_US = 2;
  localparam int SETUP_CYC = T_SETUP_US * CLK_MHZ;
  localparam int HOLD_CYC = T_HOLD_US * CLK_MHZ;
  localparam int PW_CYC = T_PW_MS * 1000 * CLK_MHZ;
  localparam int PW_MAX_CYC = T_PW_MAX_MS * 1000 * CLK_MHZ;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int DF_CYC = (T_DF_NS * CLK_MHZ + 999) / 1000;
  localparam int VPP_CYC = T_VPP_US * CLK_MHZ;
  localparam int CNT_W = 24;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic prog; // 1 = program then verify, 0 = read
  } req_t;
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic verify_err;
  } rsp_t;
  typedef struct packed {
    logic [ADDR_W-1:0] byte_address_lines;
    logic chip_select_program_strobe;
    logic oe_n;
    logic vpp_high; // 1 selects 25 V, 0 selects 5 V
  } pins_t;
endpackage

// ### hdl/eprom_ctl.sv
// controller that reads and programs a 2k x 8 uv eprom through its pins
`timescale 1ns/1ps
// How it works
// - program mode: supply 25 V, oe high, data pins are inputs.
// - address is chosen as in read while programming.
// - settle address and data, then one high strobe pulse.
// - each location pulsed exactly once, any order allowed; one pulse per job, a repeat job to a location not refused.
// - strobe pulse never above 55 ms; no static high.
// - inhibit: 25 V, oe high, strobe low means no write, pins float.
// - 25 V only in program, inhibit and verify; else 5 V.
module eprom_ctl #(
  parameter int SETUP_CYCLES = eprom_ctl_pkg::SETUP_CYC,
  parameter int HOLD_CYCLES = eprom_ctl_pkg::HOLD_CYC,
  parameter int PULSE_CYCLES = eprom_ctl_pkg::PW_CYC,
  parameter int VPP_CYCLES = eprom_ctl_pkg::VPP_CYC
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire eprom_ctl_pkg::req_t req_i,
  output logic rsp_valid_o,
  output eprom_ctl_pkg::rsp_t rsp_o,
  output eprom_ctl_pkg::pins_t pins_o,
  input wire logic [eprom_ctl_pkg::DATA_W-1:0] byte_data_pins_i,
  output logic [eprom_ctl_pkg::DATA_W-1:0] byte_data_pins_o,
  output logic byte_data_pins_oe_o
);
  // ----------------------------------------------------------------
  // state machine, gray along read and program paths except the return to ST_IDLE
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD_ACC = 4'h1,
    ST_RD_DONE = 4'h3,
    ST_VPP_UP = 4'h2,
    ST_PG_SETUP = 4'h6,
    ST_PG_PULSE = 4'h7,
    ST_PG_HOLD = 4'h5,
    ST_VF_ACC = 4'h4,
    ST_VF_DONE = 4'hc,
    ST_VPP_DOWN = 4'hd
  } state_t;

  localparam logic [eprom_ctl_pkg::CNT_W-1:0] ACC_N =
    eprom_ctl_pkg::CNT_W'(eprom_ctl_pkg::ACC_CYC);
  localparam logic [eprom_ctl_pkg::CNT_W-1:0] DF_N =
    eprom_ctl_pkg::CNT_W'(eprom_ctl_pkg::DF_CYC);
  localparam logic [eprom_ctl_pkg::CNT_W-1:0] SETUP_N =
    eprom_ctl_pkg::CNT_W'(SETUP_CYCLES);
  localparam logic [eprom_ctl_pkg::CNT_W-1:0] HOLD_N =
    eprom_ctl_pkg::CNT_W'(HOLD_CYCLES);
  localparam logic [eprom_ctl_pkg::CNT_W-1:0] PULSE_N =
    eprom_ctl_pkg::CNT_W'(PULSE_CYCLES);
  localparam logic [eprom_ctl_pkg::CNT_W-1:0] VPP_N =
    eprom_ctl_pkg::CNT_W'(VPP_CYCLES);
  localparam logic [eprom_ctl_pkg::CNT_W-1:0] CNT_ONE = 24'h000001;

  state_t state_r, state_nxt;
  logic [eprom_ctl_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  eprom_ctl_pkg::req_t job_r;
  logic [eprom_ctl_pkg::DATA_W-1:0] din_meta_r, din_sync_r;
  eprom_ctl_pkg::rsp_t rsp_r;
  logic rsp_valid_r;

  // true when the wait for this state has run out
  function automatic logic done(input logic [eprom_ctl_pkg::CNT_W-1:0] c);
    done = (c == '0);
  endfunction

  // ----------------------------------------------------------------
  // data pin synchroniser: read bytes are from another domain
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      din_meta_r <= eprom_ctl_pkg::ERASED_BYTE;
      din_sync_r <= eprom_ctl_pkg::ERASED_BYTE;
    end else begin
      din_meta_r <= byte_data_pins_i;
      din_sync_r <= din_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = done(cnt_r) ? cnt_r : cnt_r - CNT_ONE;
    case (state_r)
      ST_IDLE: begin
        if (req_valid_i) begin
          // each accepted program job gets one pulse only
          state_nxt = req_i.prog ? ST_VPP_UP : ST_RD_ACC;
          cnt_nxt = req_i.prog ? VPP_N : ACC_N + CNT_ONE;
        end
      end
      ST_RD_ACC: begin
        if (done(cnt_r)) begin
          state_nxt = ST_RD_DONE;
          cnt_nxt = DF_N;
        end
      end
      ST_RD_DONE: begin
        if (done(cnt_r)) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_VPP_UP: begin
        if (done(cnt_r)) begin
          state_nxt = ST_PG_SETUP;
          cnt_nxt = SETUP_N;
        end
      end
      ST_PG_SETUP: begin
        if (done(cnt_r)) begin
          state_nxt = ST_PG_PULSE;
          cnt_nxt = PULSE_N - CNT_ONE;
        end
      end
      ST_PG_PULSE: begin
        // fixed-length pulse, ends by count, never left high
        if (done(cnt_r)) begin
          state_nxt = ST_PG_HOLD;
          cnt_nxt = HOLD_N;
        end
      end
      ST_PG_HOLD: begin
        if (done(cnt_r)) begin
          state_nxt = ST_VF_ACC;
          cnt_nxt = ACC_N + CNT_ONE;
        end
      end
      ST_VF_ACC: begin
        if (done(cnt_r)) begin
          state_nxt = ST_VF_DONE;
          cnt_nxt = DF_N;
        end
      end
      ST_VF_DONE: begin
        if (done(cnt_r)) begin
          state_nxt = ST_VPP_DOWN;
          cnt_nxt = VPP_N;
        end
      end
      ST_VPP_DOWN: begin
        if (done(cnt_r)) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // job latch: address and data frozen for the whole job
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      job_r <= '0;
    end else if (state_r == ST_IDLE && req_valid_i) begin
      job_r <= req_i;
    end
  end

  // ----------------------------------------------------------------
  // answer: read byte, or verify result against intended data
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_r <= '0;
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      if (state_r == ST_RD_ACC && done(cnt_r)) begin
        rsp_r.data <= din_sync_r;
        rsp_r.verify_err <= 1'b0;
        rsp_valid_r <= 1'b1;
      end else if (state_r == ST_VF_ACC && done(cnt_r)) begin
        rsp_r.data <= din_sync_r;
        // a one that should be zero, or a zero that cannot return
        rsp_r.verify_err <= (din_sync_r != job_r.data);
        rsp_valid_r <= 1'b1;
      end
    end
  end

  assign req_ready_o = (state_r == ST_IDLE);
  assign rsp_valid_o = rsp_valid_r;
  assign rsp_o = rsp_r;

  // ----------------------------------------------------------------
  // pin drive, registered from state so pins never glitch
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pins_o <= '{byte_address_lines: '0, chip_select_program_strobe: 1'b1,
                  oe_n: 1'b1, vpp_high: 1'b0};
      byte_data_pins_o <= '0;
      byte_data_pins_oe_o <= 1'b0;
    end else begin
      // address moves with strobe and oe at the take edge, so the access wait counts from it
      if (state_r == ST_IDLE && req_valid_i) begin
        pins_o.byte_address_lines <= req_i.addr;
      end else begin
        pins_o.byte_address_lines <= job_r.addr;
      end
      case (state_nxt)
        ST_RD_ACC, ST_RD_DONE: begin
          // read: strobe low, oe low in ST_RD_ACC and high in ST_RD_DONE, supply at 5 V
          pins_o.chip_select_program_strobe <= 1'b0;
          pins_o.oe_n <= (state_nxt == ST_RD_DONE);
          pins_o.vpp_high <= 1'b0;
          byte_data_pins_oe_o <= 1'b0;
        end
        ST_VPP_UP, ST_PG_SETUP, ST_PG_HOLD, ST_VPP_DOWN: begin
          // inhibit level between pulses: strobe low, oe high, supply at 25 V except at 5 V in ST_VPP_DOWN
          pins_o.chip_select_program_strobe <= 1'b0;
          pins_o.oe_n <= 1'b1;
          pins_o.vpp_high <= (state_nxt != ST_VPP_DOWN);
          byte_data_pins_oe_o <= (state_nxt == ST_PG_SETUP) ||
                                 (state_nxt == ST_PG_HOLD);
        end
        ST_PG_PULSE: begin
          pins_o.chip_select_program_strobe <= 1'b1;
          pins_o.oe_n <= 1'b1;
          pins_o.vpp_high <= 1'b1;
          byte_data_pins_oe_o <= 1'b1;
        end
        ST_VF_ACC, ST_VF_DONE: begin
          pins_o.chip_select_program_strobe <= 1'b0;
          pins_o.oe_n <= (state_nxt == ST_VF_DONE);
          pins_o.vpp_high <= 1'b1;
          byte_data_pins_oe_o <= 1'b0;
        end
        default: begin
          // standby between jobs: supply back at 5 V
          pins_o.chip_select_program_strobe <= 1'b1;
          pins_o.oe_n <= 1'b1;
          pins_o.vpp_high <= 1'b0;
          byte_data_pins_oe_o <= 1'b0;
        end
      endcase
      byte_data_pins_o <= job_r.data;
    end
  end
endmodule

// ### tb/eprom_ctl_checker.sv
// checker: pin sequencing rules of the eprom controller
`timescale 1ns/1ps
module eprom_ctl_checker #(
  parameter int PULSE_CYCLES = 20 // keep small: the plain delay below unrolls
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire eprom_ctl_pkg::req_t req_i,
  input wire logic rsp_valid_o,
  input wire eprom_ctl_pkg::pins_t pins_o,
  input wire logic [eprom_ctl_pkg::DATA_W-1:0] byte_data_pins_o,
  input wire logic byte_data_pins_oe_o
);
  localparam int RD_LAT = eprom_ctl_pkg::ACC_CYC + 3;
  localparam int PW_LAST = PULSE_CYCLES - 1;
  wire s = pins_o.chip_select_program_strobe;
  wire v = pins_o.vpp_high;
  wire take = req_valid_i && req_ready_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  read_latency_a: assert property (take && !req_i.prog |-> ##RD_LAT rsp_valid_o)
    else $error("read answer late or early");
  prog_entry_a: assert property (take && req_i.prog |=> v && !s && pins_o.oe_n)
    else $error("program job does not start in inhibit");
  pulse_width_a: assert property ($rose(s) && v |-> ##PW_LAST s ##1 !s)
    else $error("program pulse width wrong");
  pulse_hold_a: assert property ($rose(s) && v |-> (s && v) [*8])
    else $error("program pulse cut short");
  data_setup_a: assert property ($rose(s) && v |-> $past(byte_data_pins_oe_o, 2))
    else $error("data not set up before pulse");
  pulse_stable_a: assert property (s && v && $past(s) |->
    $stable(pins_o.byte_address_lines) && $stable(byte_data_pins_o))
    else $error("address or data moved during pulse");
  single_pulse_a: assert property ($fell(s) && v |=> !s [*8])
    else $error("second pulse too soon");
  high_supply_a: assert property (v && s |-> pins_o.oe_n && byte_data_pins_oe_o)
    else $error("high supply with strobe high outside a pulse");
  drive_mode_a: assert property (byte_data_pins_oe_o |-> pins_o.oe_n && v)
    else $error("host drives data outside program mode");
  output_sel_a: assert property (!pins_o.oe_n |-> !s)
    else $error("output enabled while deselected");
  rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("answer held over one cycle");
endmodule
bind eprom_ctl eprom_ctl_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.mclk_i(mclk_i),
  .resetn_i(resetn_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
  .rsp_valid_o(rsp_valid_o), .pins_o(pins_o), .byte_data_pins_o(byte_data_pins_o),
  .byte_data_pins_oe_o(byte_data_pins_oe_o));

// ### tb/eprom_model.sv
// device model: 2k x 8 uv eprom array behind its mode pins
`timescale 1ns/1ps
module eprom_model (
  input wire eprom_ctl_pkg::pins_t pins_i,
  input wire logic [7:0] host_d_i,
  output logic [7:0] dev_d_o,
  output logic dev_oe_o
);
  logic [7:0] mem_r [0:2047];
  // shipped erased
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem_r[i] = eprom_ctl_pkg::ERASED_BYTE;
    end
  end
  logic armed_r = 1'b0;
  // cells only clear; a strobe kept low (inhibit) never writes
  // a write needs a whole high pulse at 25 V: entering inhibit from standby is no pulse
  always @(posedge pins_i.chip_select_program_strobe or
           negedge pins_i.chip_select_program_strobe) begin
    if (pins_i.chip_select_program_strobe) begin
      armed_r <= pins_i.vpp_high && pins_i.oe_n;
    end else begin
      if (armed_r && pins_i.vpp_high && pins_i.oe_n) begin
        mem_r[pins_i.byte_address_lines] <= mem_r[pins_i.byte_address_lines] & host_d_i;
      end
      armed_r <= 1'b0;
    end
  end
  // drives only when selected and enabled; read and verify alike
  assign dev_oe_o = !pins_i.chip_select_program_strobe && !pins_i.oe_n;
  assign dev_d_o = mem_r[pins_i.byte_address_lines];
endmodule

// ### tb/eprom_ctl_tb.sv
// testbench: reads, programs and verifies through the controller into a device model
`timescale 1ns/1ps
module eprom_ctl_tb;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req_valid_i = 1'b0;
  eprom_ctl_pkg::req_t req_i = '0;
  logic req_ready_o, rsp_valid_o, byte_data_pins_oe_o, dev_oe;
  logic junk_r = 1'b0;
  eprom_ctl_pkg::rsp_t rsp_o;
  eprom_ctl_pkg::pins_t pins_o;
  logic [7:0] byte_data_pins_o, dev_d, bus_d;
  int err_total = 0;
  int n_compared = 0;
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  // a floating bus flips every cycle, so a stale byte never passes for data
  always @(posedge mclk_i) junk_r <= ~junk_r;
  assign bus_d = dev_oe ? dev_d : (byte_data_pins_oe_o ? byte_data_pins_o : {8{junk_r}} ^ 8'h5a);
  eprom_ctl #(.SETUP_CYCLES(4), .HOLD_CYCLES(4), .PULSE_CYCLES(20), .VPP_CYCLES(4)) dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .pins_o(pins_o),
    .byte_data_pins_i(bus_d), .byte_data_pins_o(byte_data_pins_o),
    .byte_data_pins_oe_o(byte_data_pins_oe_o));
  eprom_model dev (.pins_i(pins_o), .host_d_i(bus_d), .dev_d_o(dev_d), .dev_oe_o(dev_oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one job: wait for ready, hand over, wait bounded for the answer
  task automatic xfer(input logic p, input logic [10:0] a, input logic [7:0] d,
                      input logic [7:0] ed, input logic ee);
    int n;
    n = 0;
    req_i = '{addr: a, data: d, prog: p};
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1 && n < 100) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    @(posedge mclk_i);
    #1;
    req_valid_i = 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 400) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk({7'h00, rsp_valid_o}, 8'h01);
    chk(rsp_o.data, ed);
    if (p) chk({7'h00, rsp_o.verify_err}, {7'h00, ee});
  endtask
  task automatic t_abort();
    req_i = '{addr: 11'h055, data: 8'h00, prog: 1'b1};
    req_valid_i = 1'b1;
    @(posedge mclk_i);
    #1;
    req_valid_i = 1'b0;
    repeat (12) @(posedge mclk_i);
    #1;
    resetn_i = 1'b0;
    @(posedge mclk_i);
    #1;
    chk({5'h00, pins_o.vpp_high, pins_o.oe_n, byte_data_pins_oe_o}, 8'h02);
    resetn_i = 1'b1;
    xfer(1'b0, 11'h055, 8'h00, 8'hff, 1'b0);
    $display("test abort done");
  endtask
  task automatic t_erased();
    xfer(1'b0, 11'h000, 8'h00, 8'hff, 1'b0);
    xfer(1'b0, 11'h7ff, 8'h00, 8'hff, 1'b0);
    $display("test erased done");
  endtask
  task automatic t_program();
    xfer(1'b1, 11'h123, 8'ha5, 8'ha5, 1'b0);
    xfer(1'b1, 11'h7ff, 8'h3c, 8'h3c, 1'b0);
    xfer(1'b0, 11'h123, 8'h00, 8'ha5, 1'b0);
    xfer(1'b0, 11'h124, 8'h00, 8'hff, 1'b0);
    $display("test program done");
  endtask
  task automatic t_no_set();
    xfer(1'b1, 11'h123, 8'h5a, 8'h00, 1'b1);
    xfer(1'b0, 11'h123, 8'h00, 8'h00, 1'b0);
    $display("test no set done");
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    #1;
    resetn_i = 1'b1;
    t_abort();
    t_erased();
    t_program();
    t_no_set();
    finish_test();
  end
  // watchdog: between three and four times the expected run
  initial begin
    #25000;
    err_total++;
    finish_test();
  end
endmodule
